// ### verilog/afr_pkg.sv
package afr_pkg;

  // ----------------------------------------------------------------
  // Geometry and types
  // ----------------------------------------------------------------
  typedef logic [10:0] coord_t;
  typedef logic [15:0] value_t;

  typedef enum logic [2:0] {
    MODE_OFF  = 3'h1,
    MODE_ONCE = 3'h2,
    MODE_CONT = 3'h4
  } mode_e;

  localparam coord_t SENSOR_W = 11'h640;
  localparam coord_t SENSOR_H = 11'h4B0;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_CROP_POS  = 8'h04;
  localparam logic [7:0] ADDR_CROP_SIZE = 8'h08;
  localparam logic [7:0] ADDR_WIN_SEL   = 8'h0C;
  localparam logic [7:0] ADDR_WIN_POS   = 8'h10;
  localparam logic [7:0] ADDR_WIN_SIZE  = 8'h14;
  localparam logic [7:0] ADDR_TARGET    = 8'h18;
  localparam logic [7:0] LOOP_BASE      = 8'h20;
  localparam logic [7:0] LOOP_STRIDE    = 8'h10;
  localparam logic [7:0] OFS_MODE       = 8'h00;
  localparam logic [7:0] OFS_VALUE      = 8'h04;
  localparam logic [7:0] OFS_LIMITS     = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h50;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] TARGET_RST       = 8'h80;
  localparam logic [7:0] TARGET_TOL       = 8'h04;
  localparam value_t     VALUE_RST        = 16'h0100;
  localparam value_t     LIMIT_LO_RST     = 16'h0000;
  localparam value_t     LIMIT_HI_RST     = 16'hFFFF;
  localparam value_t     STEP             = 16'h0001;
  localparam logic [6:0] ONCE_FRAMES_SLOW = 7'h32;
  localparam logic [6:0] ONCE_FRAMES_FAST = 7'h64;
  localparam logic [1:0] SETTLE_FRAMES    = 2'h2;

  // True when p lies in [start, start + len).
  function automatic logic in_span(input coord_t p, input coord_t start, input coord_t len);
    return (p >= start) && ({1'b0, p} < ({1'b0, start} + {1'b0, len}));
  endfunction

  // Limits a widened value to [lo, hi].
  function automatic value_t clamp(input logic [16:0] v, input value_t lo, input value_t hi);
    if (v < {1'b0, lo}) begin
      return lo;
    end
    if (v > {1'b0, hi}) begin
      return hi;
    end
    return v[15:0];
  endfunction

endpackage

// ### verilog/stats_if.sv
`timescale 1ns/1ps
`default_nettype none
interface stats_if;
  logic        done;
  logic [31:0] sum;
  logic [20:0] cnt;
  modport src (output done, sum, cnt);
  modport snk (input done, sum, cnt);
endinterface
`default_nettype wire

// ### verilog/stats_acc.sv
`timescale 1ns/1ps
`default_nettype none
module stats_acc import afr_pkg::*; (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  // Pixel stream
  input  wire logic       pix_valid_i,
  input  wire logic       pix_eof_i,
  input  wire logic [7:0] pix_data_i,
  input  wire coord_t     col_i,
  input  wire coord_t     row_i,
  // Window and crop
  input  wire coord_t     win_col_i,
  input  wire coord_t     win_row_i,
  input  wire coord_t     win_w_i,
  input  wire coord_t     win_h_i,
  input  wire coord_t     crop_col_i,
  input  wire coord_t     crop_row_i,
  input  wire coord_t     crop_w_i,
  input  wire coord_t     crop_h_i,
  // Frame result
  stats_if.src            st
);

  logic        hit;
  logic        last;
  logic [31:0] sum_q;
  logic [20:0] cnt_q;
  logic [31:0] add_sum;
  logic [20:0] add_cnt;

  // Only pixels inside both the window and the crop count.
  assign hit = pix_valid_i && in_span(col_i, win_col_i, win_w_i) && in_span(row_i, win_row_i, win_h_i)
               && in_span(col_i, crop_col_i, crop_w_i) && in_span(row_i, crop_row_i, crop_h_i);
  assign last    = pix_valid_i && pix_eof_i;
  assign add_sum = sum_q + (hit ? {24'h000000, pix_data_i} : 32'h00000000);
  assign add_cnt = cnt_q + {20'h00000, hit};

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      sum_q   <= 32'h00000000;
      cnt_q   <= 21'h000000;
      st.done <= 1'b0;
      st.sum  <= 32'h00000000;
      st.cnt  <= 21'h000000;
    end else begin
      st.done <= last;
      if (last) begin
        st.sum <= add_sum;
        st.cnt <= add_cnt;
        sum_q  <= 32'h00000000;
        cnt_q  <= 21'h000000;
      end else begin
        sum_q <= add_sum;
        cnt_q <= add_cnt;
      end
    end
  end

  frame_done_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) last |=> st.done)
    else $error("frame result not published after last pixel");

endmodule
`default_nettype wire

// ### verilog/auto_loop.sv
`timescale 1ns/1ps
`default_nettype none
module auto_loop import afr_pkg::*; (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  // Window statistics
  stats_if.snk            st,
  // Software settings
  input  wire logic       fast_i,
  input  wire logic [7:0] target_i,
  input  wire value_t     lower_i,
  input  wire value_t     upper_i,
  input  wire logic       mode_wr_i,
  input  wire mode_e      mode_data_i,
  input  wire logic       val_wr_i,
  input  wire value_t     val_data_i,
  // Loop state
  output mode_e           mode_o,
  output value_t          value_o,
  output logic            timeout_o
);

  mode_e       mode_q;
  value_t      value_q;
  logic        timeout_q;
  logic        skip_q;
  logic [6:0]  once_cnt_q;
  logic [1:0]  settle_q;
  logic [8:0]  tgt_lo;
  logic [8:0]  tgt_hi;
  logic [31:0] lo_thr;
  logic [31:0] hi_thr;
  logic [6:0]  once_lim;
  logic        below;
  logic        above;
  logic        due;
  logic        once_end;
  logic        tmo_set;
  logic [16:0] stepped;

  assign tgt_lo   = (target_i > TARGET_TOL) ? {1'b0, target_i - TARGET_TOL} : 9'h000;
  assign tgt_hi   = {1'b0, target_i} + {1'b0, TARGET_TOL};
  // Both factors are widened first so that a full-sensor pixel count cannot overflow the product.
  assign lo_thr   = 32'(tgt_lo) * 32'(st.cnt);
  assign hi_thr   = 32'(tgt_hi) * 32'(st.cnt);
  assign below    = st.sum < lo_thr;
  assign above    = st.sum > hi_thr;
  assign once_lim = fast_i ? ONCE_FRAMES_FAST : ONCE_FRAMES_SLOW;
  // An empty intersection or a settling loop makes no step.
  assign due = st.done && (st.cnt != 21'h000000) && (settle_q == 2'h0)
               && ((mode_q == MODE_ONCE) || ((mode_q == MODE_CONT) && !(fast_i && skip_q)));
  assign stepped  = below ? ({1'b0, value_q} + {1'b0, STEP})
                  : above ? ((value_q > STEP) ? {1'b0, value_q - STEP} : 17'h00000) : {1'b0, value_q};
  assign once_end = st.done && (mode_q == MODE_ONCE)
                    && ((due && !below && !above) || ((once_cnt_q + 7'h01) >= once_lim));
  assign tmo_set  = once_end && !(due && !below && !above);
  assign mode_o    = mode_q;
  assign value_o   = value_q;
  assign timeout_o = timeout_q;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      value_q <= VALUE_RST;
      skip_q  <= 1'b0;
    end else begin
      if (st.done) begin
        skip_q <= !skip_q;
      end
      if (due) begin
        value_q <= clamp(stepped, lower_i, upper_i);
      end else if (val_wr_i) begin
        value_q <= val_data_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      mode_q     <= MODE_CONT;
      once_cnt_q <= 7'h00;
      settle_q   <= SETTLE_FRAMES;
    end else if (mode_wr_i) begin
      mode_q     <= mode_data_i;
      once_cnt_q <= 7'h00;
      settle_q   <= SETTLE_FRAMES;
    end else begin
      if (once_end) begin
        mode_q <= MODE_OFF;
      end
      if (st.done && (mode_q == MODE_ONCE)) begin
        once_cnt_q <= once_cnt_q + 7'h01;
      end
      if (st.done && (settle_q != 2'h0)) begin
        settle_q <= settle_q - 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      timeout_q <= 1'b0;
    end else if (tmo_set) begin
      timeout_q <= 1'b1;
    end else if (mode_wr_i) begin
      timeout_q <= 1'b0;
    end
  end

  off_hold_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (mode_q == MODE_OFF) && !val_wr_i |=> $stable(value_q))
    else $error("value moved while loop is off");

  once_timeout_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    st.done && (mode_q == MODE_ONCE) && !mode_wr_i && ((once_cnt_q + 7'h01) == once_lim) |=> mode_q == MODE_OFF)
    else $error("single-shot loop did not stop at frame limit");

endmodule
`default_nettype wire

// ### verilog/auto_function_region_control.sv
// How it works
// - Single-shot keeps stepping until target is reached.
// - Single-shot success turns loop off, keeps value.
// - Single-shot gives up after 50/100 frames.
// - Continuous mode is each loop's reset default.
// - Continuous steps every frame or every other.
// - Continuous runs until single-shot or off chosen.
// - Off holds last automatic value until manual write.
// - Automatic steps overwrite the manual value.
// - Unreachable target is approached, never forced.
// - Loop and setting writes accepted during capture.
// - Newly enabled loop may wait a few frames.
// - Two independent statistics windows exist.
// - Window one feeds exposure and gain loops.
// - Window two feeds the white-balance loop.
// - Window-to-loop assignment is fixed in hardware.
// - Windows are column, row, width, height from origin.
// - Windows cover the whole sensor after reset.
// - Selector picks which window position writes hit.
// - Window settings are independent of the crop.
// - Statistics come only from window-crop intersection.
// - No intersection means no adjustment.
`timescale 1ns/1ps
`default_nettype none
module auto_function_region_control import afr_pkg::*; (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  // AXI4-Lite write address and data
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  // AXI4-Lite write response
  output logic             bvalid_o,
  input  wire logic        bready_i,
  output logic [1:0]       bresp_o,
  // AXI4-Lite read
  input  wire logic        arvalid_i,
  output logic             arready_o,
  input  wire logic [7:0]  araddr_i,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  // Pixel stream
  input  wire logic        pix_valid_i,
  input  wire logic        pix_sof_i,
  input  wire logic        pix_eol_i,
  input  wire logic        pix_eof_i,
  input  wire logic [7:0]  pix_data_i,
  // Controlled parameters
  output value_t           exposure_o,
  output value_t           gain_o,
  output value_t           balance_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  logic        fast_q;
  logic        sel_q;
  logic [7:0]  target_q;
  coord_t      crop_col_q;
  coord_t      crop_row_q;
  coord_t      crop_w_q;
  coord_t      crop_h_q;
  coord_t      win_col_q [2];
  coord_t      win_row_q [2];
  coord_t      win_w_q   [2];
  coord_t      win_h_q   [2];
  value_t      lim_lo_q  [3];
  value_t      lim_hi_q  [3];
  coord_t      col_q;
  coord_t      row_q;

  mode_e       loop_mode [3];
  value_t      loop_val  [3];
  logic [2:0]  loop_tmo;
  logic [2:0]  mode_wr;
  logic [2:0]  val_wr;
  logic [2:0]  lim_wr;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  logic        wr_fire;
  logic [32:0] cur_w;
  logic [32:0] rd_w;
  logic [31:0] wd;
  logic        mode_ok;
  coord_t      col_cur;
  coord_t      row_cur;

  // Returns {mapped, data} for one register address.
  function automatic logic [32:0] reg_read(input logic [7:0] a);
    logic [32:0] r;
    logic [7:0]  b;
    r = {1'b1, 32'h00000000};
    case (a)
      ADDR_CTRL:      r[31:0] = {31'h00000000, fast_q};
      ADDR_CROP_POS:  r[31:0] = {5'h00, crop_row_q, 5'h00, crop_col_q};
      ADDR_CROP_SIZE: r[31:0] = {5'h00, crop_h_q, 5'h00, crop_w_q};
      ADDR_WIN_SEL:   r[31:0] = {31'h00000000, sel_q};
      ADDR_WIN_POS:   r[31:0] = {5'h00, win_row_q[sel_q], 5'h00, win_col_q[sel_q]};
      ADDR_WIN_SIZE:  r[31:0] = {5'h00, win_h_q[sel_q], 5'h00, win_w_q[sel_q]};
      ADDR_TARGET:    r[31:0] = {24'h000000, target_q};
      ADDR_STATUS:    r[31:0] = {29'h00000000, loop_tmo};
      default: begin
        r[32] = 1'b0;
        for (int i = 0; i < 3; i++) begin
          b = LOOP_BASE + 8'(LOOP_STRIDE * 8'(i));
          if (a == b + OFS_MODE) begin
            r = {1'b1, 29'h00000000, loop_mode[i]};
          end
          if (a == b + OFS_VALUE) begin
            r = {1'b1, 16'h0000, loop_val[i]};
          end
          if (a == b + OFS_LIMITS) begin
            r = {1'b1, lim_hi_q[i], lim_lo_q[i]};
          end
        end
      end
    endcase
    return r;
  endfunction

  // Applies byte enables over the register's present value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  assign wr_fire = !awready_q && !wready_q && !bvalid_q;
  // A process, not an assign, so that register changes seen inside the function re-evaluate it.
  always_comb begin
    cur_w = reg_read(aw_addr_q);
    rd_w  = reg_read(araddr_i);
  end
  assign wd      = merge(cur_w[31:0], w_data_q, w_strb_q);
  assign mode_ok = (wd[2:0] == MODE_OFF) || (wd[2:0] == MODE_ONCE) || (wd[2:0] == MODE_CONT);
  assign col_cur = pix_sof_i ? 11'h000 : col_q;
  assign row_cur = pix_sof_i ? 11'h000 : row_q;

  assign awready_o  = awready_q;
  assign wready_o   = wready_q;
  assign bvalid_o   = bvalid_q;
  assign bresp_o    = bresp_q;
  assign arready_o  = arready_q;
  assign rvalid_o   = rvalid_q;
  assign rdata_o    = rdata_q;
  assign rresp_o    = rresp_q;
  assign exposure_o = loop_val[0];
  assign gain_o     = loop_val[1];
  assign balance_o  = loop_val[2];

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
    end else begin
      if (awvalid_i && awready_q) begin
        aw_addr_q <= awaddr_i;
        awready_q <= 1'b0;
      end
      if (wvalid_i && wready_q) begin
        w_data_q <= wdata_i;
        w_strb_q <= wstrb_i;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q  <= 1'b1;
        bresp_q   <= cur_w[32] ? RESP_OKAY : RESP_SLVERR;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end else if (bvalid_q && bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OKAY;
    end else if (arvalid_i && arready_q) begin
      rdata_q   <= rd_w[31:0];
      rresp_q   <= rd_w[32] ? RESP_OKAY : RESP_SLVERR;
      rvalid_q  <= 1'b1;
      arready_q <= 1'b0;
    end else if (rvalid_q && rready_i) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Global settings and crop
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      fast_q     <= 1'b0;
      sel_q      <= 1'b0;
      target_q   <= TARGET_RST;
      crop_col_q <= 11'h000;
      crop_row_q <= 11'h000;
      crop_w_q   <= SENSOR_W;
      crop_h_q   <= SENSOR_H;
    end else if (wr_fire) begin
      case (aw_addr_q)
        ADDR_CTRL:      fast_q <= wd[0];
        ADDR_WIN_SEL:   sel_q <= wd[0];
        ADDR_TARGET:    target_q <= wd[7:0];
        ADDR_CROP_POS:  {crop_row_q, crop_col_q} <= {wd[26:16], wd[10:0]};
        ADDR_CROP_SIZE: {crop_h_q, crop_w_q} <= {wd[26:16], wd[10:0]};
        default:        fast_q <= fast_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Statistics windows, kept apart from the crop
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 2; i++) begin
        win_col_q[i] <= 11'h000;
        win_row_q[i] <= 11'h000;
        win_w_q[i]   <= SENSOR_W;
        win_h_q[i]   <= SENSOR_H;
      end
    end else if (wr_fire && (aw_addr_q == ADDR_WIN_POS)) begin
      win_col_q[sel_q] <= wd[10:0];
      win_row_q[sel_q] <= wd[26:16];
    end else if (wr_fire && (aw_addr_q == ADDR_WIN_SIZE)) begin
      win_w_q[sel_q] <= wd[10:0];
      win_h_q[sel_q] <= wd[26:16];
    end
  end

  // ----------------------------------------------------------------
  // Pixel position
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      col_q <= 11'h000;
      row_q <= 11'h000;
    end else if (pix_valid_i && pix_eol_i) begin
      col_q <= 11'h000;
      row_q <= row_cur + 11'h001;
    end else if (pix_valid_i) begin
      col_q <= col_cur + 11'h001;
      row_q <= row_cur;
    end
  end

  // ----------------------------------------------------------------
  // Window statistics and loops
  // ----------------------------------------------------------------
  stats_if st_if [2] ();

  for (genvar w = 0; w < 2; w++) begin : g_win
    stats_acc u_acc (
      .sys_clk_i   (sys_clk_i),
      .nrst_i      (nrst_i),
      .pix_valid_i (pix_valid_i),
      .pix_eof_i   (pix_eof_i),
      .pix_data_i  (pix_data_i),
      .col_i       (col_cur),
      .row_i       (row_cur),
      .win_col_i   (win_col_q[w]),
      .win_row_i   (win_row_q[w]),
      .win_w_i     (win_w_q[w]),
      .win_h_i     (win_h_q[w]),
      .crop_col_i  (crop_col_q),
      .crop_row_i  (crop_row_q),
      .crop_w_i    (crop_w_q),
      .crop_h_i    (crop_h_q),
      .st          (st_if[w])
    );
  end

  for (genvar i = 0; i < 3; i++) begin : g_loop
    localparam logic [7:0] BASE = LOOP_BASE + 8'(LOOP_STRIDE * 8'(i));
    assign mode_wr[i] = wr_fire && (aw_addr_q == BASE + OFS_MODE) && mode_ok;
    assign val_wr[i]  = wr_fire && (aw_addr_q == BASE + OFS_VALUE);
    assign lim_wr[i]  = wr_fire && (aw_addr_q == BASE + OFS_LIMITS);

    always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
        lim_lo_q[i] <= LIMIT_LO_RST;
        lim_hi_q[i] <= LIMIT_HI_RST;
      end else if (lim_wr[i]) begin
        lim_lo_q[i] <= wd[15:0];
        lim_hi_q[i] <= wd[31:16];
      end
    end

    // Exposure and gain share window one, white balance uses window two.
    auto_loop u_loop (
      .sys_clk_i   (sys_clk_i),
      .nrst_i      (nrst_i),
      .st          (st_if[(i == 2) ? 1 : 0]),
      .fast_i      (fast_q),
      .target_i    (target_q),
      .lower_i     (lim_lo_q[i]),
      .upper_i     (lim_hi_q[i]),
      .mode_wr_i   (mode_wr[i]),
      .mode_data_i (mode_e'(wd[2:0])),
      .val_wr_i    (val_wr[i]),
      .val_data_i  (wd[15:0]),
      .mode_o      (loop_mode[i]),
      .value_o     (loop_val[i]),
      .timeout_o   (loop_tmo[i])
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  reset_mode_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> (loop_mode[0] == MODE_CONT) && (loop_mode[1] == MODE_CONT) && (loop_mode[2] == MODE_CONT))
    else $error("loops not continuous after reset");

  reset_window_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> (win_w_q[1] == SENSOR_W) && (win_h_q[0] == SENSOR_H) && (win_col_q[0] == 11'h000))
    else $error("window not full sensor after reset");

  window_select_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    wr_fire && (aw_addr_q == ADDR_WIN_POS) && !sel_q |=> $stable(win_col_q[1]) && (win_col_q[0] == $past(wd[10:0])))
    else $error("position write reached the unselected window");

  crop_apart_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    wr_fire && (aw_addr_q == ADDR_CROP_SIZE) |=> $stable(win_w_q[0]) && $stable(win_w_q[1]))
    else $error("crop write changed a statistics window");

  write_answer_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    wr_fire |=> bvalid_q && awready_q && wready_q)
    else $error("write response missing after write");

endmodule
`default_nettype wire

// ### testbench/auto_function_region_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module auto_function_region_control_test import afr_pkg::*;;
  logic        sys_clk_i = 0, nrst_i = 0, awvalid_i = 0, wvalid_i = 0, arvalid_i = 0;
  logic        pix_valid_i = 0, pix_sof_i = 0, pix_eol_i = 0, pix_eof_i = 0;
  logic [7:0]  awaddr_i = 0, araddr_i = 0, pix_data_i = 0;
  logic [31:0] wdata_i = 0, rdata_o, rd_q;
  logic [1:0]  bresp_o, rresp_o, rr, br;
  logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  value_t      exposure_o, gain_o, balance_o;
  int          bad_count = 0, samples_checked = 0, e = 256, g = 256, b = 256, i;

  auto_function_region_control i_dut (.*, .wstrb_i(4'hF), .bready_i(1'b1), .rready_i(1'b1));

  initial forever #5 sys_clk_i = ~sys_clk_i;

  // ------------------------------------------------------------
  // Bus, pixel and comparison tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
    samples_checked++;
    if (y !== x) begin
      $display("mismatch %s expected %h seen %h", n, x, y);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1;
    wvalid_i <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk_i);
      if (awready_o === 1'b1) awvalid_i <= 0;
      if (wready_o === 1'b1) wvalid_i <= 0;
      if (bvalid_o === 1'b1) begin
        br = bresp_o;
        break;
      end
    end
    if (n == 20) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    araddr_i <= a;
    arvalid_i <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk_i);
      if (arready_o === 1'b1) arvalid_i <= 0;
      if (rvalid_o === 1'b1) begin
        rd_q = rdata_o;
        rr = rresp_o;
        break;
      end
    end
    if (n == 20) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  // Sends one 4x4 frame whose pixels lie in [base, base + span).
  task automatic frm(input int base, input int span);
    for (int k = 0; k < 16; k++) begin
      @(posedge sys_clk_i);
      pix_valid_i <= 1;
      pix_sof_i <= (k == 0);
      pix_eol_i <= (k % 4 == 3);
      pix_eof_i <= (k == 15);
      pix_data_i <= 8'(base + $urandom % span);
    end
    @(posedge sys_clk_i);
    pix_valid_i <= 0;
    pix_sof_i <= 0;
    pix_eol_i <= 0;
    pix_eof_i <= 0;
    repeat (3) @(posedge sys_clk_i);
  endtask

  task automatic outs;
    chk("exposure", e, exposure_o);
    chk("gain", g, gain_o);
    chk("balance", b, balance_o);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h801c));
    repeat (16) @(posedge sys_clk_i);
    nrst_i <= 1;
    @(posedge sys_clk_i);
    outs();
    rd(LOOP_BASE);
    chk("mode", MODE_CONT, rd_q);
    rd(8'h5C);
    chk("resp", RESP_SLVERR, rr);
    wr(ADDR_WIN_SEL, 1);
    chk("bresp", RESP_OKAY, br);
    wr(ADDR_WIN_SIZE, 32'h04B005DC);
    wr(ADDR_WIN_POS, 32'h64);
    rd(ADDR_WIN_POS);
    chk("win", 32'h64, rd_q);
    wr(ADDR_WIN_SEL, 0);
    wr(ADDR_WIN_POS, 0);
    rd(ADDR_WIN_POS);
    chk("win", 0, rd_q);
    wr(ADDR_CROP_SIZE, 32'h00080008);
    rd(ADDR_WIN_SIZE);
    chk("win", 32'h04B00640, rd_q);
    wr(8'h5C, 0);
    chk("bresp", RESP_SLVERR, br);
    // Dark frames raise both window-one loops; window two sees no pixels.
    for (i = 0; i < 6; i++) begin
      frm(0, 64);
      if (i > 1) begin
        e++;
        g++;
      end
      outs();
    end
    wr(LOOP_BASE + LOOP_STRIDE, MODE_ONCE);
    repeat (4) frm(126, 5);
    outs();
    rd(LOOP_BASE + LOOP_STRIDE);
    chk("mode", MODE_OFF, rd_q);
    wr(8'h34, 32'h200);
    wr(8'h24, 32'h300);
    frm(0, 64);
    g = 512;
    e = 769;
    outs();
    wr(LOOP_BASE, MODE_ONCE);
    repeat (50) frm(0, 64);
    rd(LOOP_BASE);
    chk("mode", MODE_OFF, rd_q);
    rd(ADDR_STATUS);
    chk("status", 1, rd_q);
    e = 817;
    outs();
    wr(ADDR_CTRL, 1);
    wr(LOOP_BASE + LOOP_STRIDE, MODE_CONT);
    repeat (6) frm(0, 64);
    g = 514;
    outs();
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge sys_clk_i);
    bad_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
